/* File: hw/psc_pkg.sv */
/*
 Holds the constants, types and register map of the pump staging controller.
 Assumes a 10 MHz system clock and a classic Wishbone master with 32-bit data.
*/
// Function
// (R1) Mode zero keeps the controller idle with all staging relays off.
// (R2) Mode one removes mains pumps last-on first-off; stop halts every pump.
// (R3) Modes two and five stop only the drive pump, relays stay energised.
// (R4) Mode three removes oldest pump first for equal wear; stop halts all.
// (R5) Mode four moves the drive between motors, removes oldest first, stop halts all.
// (R6) Mode six cycles over three motors, oldest first, stop halts all.
// (R7) Without the relay extension the mode is forced to zero.
// (R8) Fixed modes keep one pump on the drive, eight pumps at most.
// (R9) Cycle modes rotate the drive pump, four pumps at most.
// (R10) First enable field: bit zero reserved, bits one to three enable relays two to four.
// (R11) Second enable field: bits zero to three enable relays five to eight.
// (R12) Fixed modes stage any enabled subset of relays two to eight.
// (R13) Fixed modes hold PID and ramp to the limit when staging, then resume.
// (R14) Cycle modes use relays one, two and whole enabled pairs only.
// (R15) Cycle add: disconnect drive, move motor to mains, wait, drive next motor.
// (R16) Add a pump after the upper-duration time at the upper threshold.
// (R17) Remove a pump after the lower-duration time at the lower threshold.
// (R18) Every drive/mains transfer waits the contactor switch time.
// (R19) The switch time must exceed the contactor's slower operate time.
// (R20) Thresholds are limits moved inward by the bias, 0.1 percent steps, 20 percent max.
// (R21) Duration timers restart when the frequency leaves its threshold region.
package psc_pkg;
   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] ADR_MODE = 8'h00;
   localparam logic [7:0] ADR_RELAY_EN = 8'h04;
   localparam logic [7:0] ADR_UP_DUR = 8'h08;
   localparam logic [7:0] ADR_LO_DUR = 8'h0c;
   localparam logic [7:0] ADR_SW_TIME = 8'h10;
   localparam logic [7:0] ADR_BIAS = 8'h14;
   localparam logic [7:0] ADR_STATUS = 8'h18;
   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int EN_HI_POS = 4;
   localparam int ST_MAINS_POS = 8;
   localparam int ST_DRIVE_POS = 16;
   localparam int ST_STATE_POS = 20;
   localparam int ST_CNT_POS = 24;
   localparam logic [2:0] MODE_OFF = 3'h0;
   localparam logic [2:0] MODE_LIFO = 3'h1;
   localparam logic [2:0] MODE_FIX_HOLD = 3'h2;
   localparam logic [2:0] MODE_FIX_FIFO = 3'h3;
   localparam logic [2:0] MODE_CYC_FIFO = 3'h4;
   localparam logic [2:0] MODE_CYC_HOLD = 3'h5;
   localparam logic [2:0] MODE_CYC3 = 3'h6;
   localparam logic [15:0] UP_DUR_RST = 16'h000a;
   localparam logic [15:0] LO_DUR_RST = 16'h000a;
   localparam logic [7:0] SW_TIME_RST = 8'h0a;
   localparam logic [7:0] BIAS_RST = 8'h00;
   // ----------------------------------------------------------------
   // Limits and timing; durations in 0.1 s, switch time in 0.01 s
   // ----------------------------------------------------------------
   localparam logic [15:0] DUR_MIN = 16'h000a;
   localparam logic [15:0] DUR_MAX = 16'h1770;
   localparam logic [7:0] SW_MIN = 8'h0a;
   localparam logic [7:0] SW_MAX = 8'hc8;
   localparam logic [7:0] BIAS_MAX = 8'hc8;
   localparam logic [4:0] TICKS_PER_DUR = 5'h0a;
   localparam int CLK_PERIOD_NS = 100;
   localparam int TICK_TIME_NS = 10000000;
   localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;
   localparam int NUM_PUMPS = 8;
   localparam int CYC_PUMPS = 4;
   localparam int CYC3_PUMPS = 3;
   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {PS_IDLE, PS_RUN, PS_RAMP, PS_XFER_OFF, PS_XFER_ON} psc_state_e;
   typedef struct packed {
      logic [2:0] mode;
      logic [3:0] en_lo;
      logic [3:0] en_hi;
      logic [15:0] up_dur;
      logic [15:0] lo_dur;
      logic [7:0] sw_time;
      logic [7:0] bias;
   } psc_cfg_s;
endpackage : psc_pkg

/* File: hw/psc_top.sv */
/*
 Pump staging controller: Wishbone register slave, threshold timers, staging
 sequencer and relay drivers. Assumes the drive supplies output frequency and
 limits in 0.1 percent units, synchronous to sys_clk, and a level run command.
*/
// Added by the designer: the Wishbone slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
module psc_top #(
   parameter int TICK_CYCLES = psc_pkg::TICK_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic card_present,
   input wire logic run_cmd,
   input wire logic [9:0] out_freq,
   input wire logic [9:0] upper_limit,
   input wire logic [9:0] lower_limit,
   output logic [7:0] staging_relays,
   output logic drive_run,
   output logic pid_hold,
   output logic ramp_to_upper,
   output logic ramp_to_lower
);
   // ----------------------------------------------------------------
   // Register bus
   // ----------------------------------------------------------------
   localparam psc_pkg::psc_state_e PS_IDLE = psc_pkg::PS_IDLE;
   localparam psc_pkg::psc_state_e PS_RUN = psc_pkg::PS_RUN;
   localparam psc_pkg::psc_state_e PS_RAMP = psc_pkg::PS_RAMP;
   localparam psc_pkg::psc_state_e PS_XFER_OFF = psc_pkg::PS_XFER_OFF;
   localparam psc_pkg::psc_state_e PS_XFER_ON = psc_pkg::PS_XFER_ON;
   psc_pkg::psc_cfg_s cfg_reg;
   psc_pkg::psc_state_e state_reg, state_next;
   logic [7:0] mains_reg, mains_next;
   logic [1:0] drive_reg, drive_next;
   logic conn_reg, conn_next;
   logic [2:0] order_reg [0:7];
   logic [2:0] order_next [0:7];
   logic [3:0] cnt_reg, cnt_next;
   logic ramp_up_reg, ramp_up_next;
   wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire bus_wr = bus_req && wb_we_i;
   wire [31:0] status_word = {4'h0, cnt_reg, 1'b0, state_reg, 2'h0, drive_reg,
                              mains_reg, staging_relays};
   wire [31:0] rd_word =
      (wb_adr_i == psc_pkg::ADR_MODE) ? {29'h0, cfg_reg.mode} :
      (wb_adr_i == psc_pkg::ADR_RELAY_EN) ? {24'h0, cfg_reg.en_hi, cfg_reg.en_lo} :
      (wb_adr_i == psc_pkg::ADR_UP_DUR) ? {16'h0, cfg_reg.up_dur} :
      (wb_adr_i == psc_pkg::ADR_LO_DUR) ? {16'h0, cfg_reg.lo_dur} :
      (wb_adr_i == psc_pkg::ADR_SW_TIME) ? {24'h0, cfg_reg.sw_time} :
      (wb_adr_i == psc_pkg::ADR_BIAS) ? {24'h0, cfg_reg.bias} :
      (wb_adr_i == psc_pkg::ADR_STATUS) ? status_word : 32'h0;
   wire [15:0] wr_half = {wb_sel_i[1] ? wb_dat_i[15:8] : 8'h0, wb_dat_i[7:0]};

   function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo,
                                          input logic [15:0] hi);
      clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction : clamp16

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end
      else
      begin
         wb_ack_o <= bus_req;
         wb_dat_o <= bus_req ? rd_word : 32'h0;
      end
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         cfg_reg.mode <= psc_pkg::MODE_OFF;
         cfg_reg.en_lo <= 4'h0;
         cfg_reg.en_hi <= 4'h0;
         cfg_reg.up_dur <= psc_pkg::UP_DUR_RST;
         cfg_reg.lo_dur <= psc_pkg::LO_DUR_RST;
         cfg_reg.sw_time <= psc_pkg::SW_TIME_RST;
         cfg_reg.bias <= psc_pkg::BIAS_RST;
      end
      else if (bus_wr && wb_sel_i[0])
      begin
         case (wb_adr_i)
            psc_pkg::ADR_MODE: cfg_reg.mode <= (wb_dat_i[2:0] > psc_pkg::MODE_CYC3) ?
                                               psc_pkg::MODE_OFF : wb_dat_i[2:0];
            psc_pkg::ADR_RELAY_EN:
            begin
               cfg_reg.en_lo <= {wb_dat_i[3:1], 1'b0}; // R10
               cfg_reg.en_hi <= wb_dat_i[psc_pkg::EN_HI_POS +: 4]; // R11
            end
            psc_pkg::ADR_UP_DUR:
               cfg_reg.up_dur <= clamp16(wr_half, psc_pkg::DUR_MIN, psc_pkg::DUR_MAX); // R16
            psc_pkg::ADR_LO_DUR:
               cfg_reg.lo_dur <= clamp16(wr_half, psc_pkg::DUR_MIN, psc_pkg::DUR_MAX); // R17
            psc_pkg::ADR_SW_TIME: cfg_reg.sw_time <= 8'(clamp16({8'h0, wb_dat_i[7:0]},
               {8'h0, psc_pkg::SW_MIN}, {8'h0, psc_pkg::SW_MAX})); // R18
            psc_pkg::ADR_BIAS: cfg_reg.bias <= (wb_dat_i[7:0] > psc_pkg::BIAS_MAX) ?
                                               psc_pkg::BIAS_MAX : wb_dat_i[7:0]; // R20
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Mode decode and pump pool
   // ----------------------------------------------------------------
   wire [2:0] mode_eff = card_present ? cfg_reg.mode : psc_pkg::MODE_OFF; // R7
   wire active = mode_eff != psc_pkg::MODE_OFF; // R1
   wire cyc_mode = (mode_eff == psc_pkg::MODE_CYC_FIFO) || (mode_eff == psc_pkg::MODE_CYC_HOLD) ||
                   (mode_eff == psc_pkg::MODE_CYC3);
   wire hold_on_stop = (mode_eff == psc_pkg::MODE_FIX_HOLD) ||
                       (mode_eff == psc_pkg::MODE_CYC_HOLD); // R3
   wire lifo = mode_eff == psc_pkg::MODE_LIFO; // R2 R4 R5 R6
   wire [7:0] en_all = {cfg_reg.en_hi, cfg_reg.en_lo};
   wire [7:0] fix_pool = {en_all[7:1], 1'b0}; // R8 R12
   logic [3:0] cyc_pool;
   genvar gp;
   generate
      for (gp = 0; gp < psc_pkg::CYC_PUMPS; gp++)
      begin : g_pair
         if (gp == 0)
         begin : g_first
            assign cyc_pool[gp] = 1'b1; // R14
         end
         else
         begin : g_rest
            assign cyc_pool[gp] = en_all[2*gp] && en_all[2*gp+1] &&
               !((mode_eff == psc_pkg::MODE_CYC3) && (gp >= psc_pkg::CYC3_PUMPS)); // R6 R9 R14
         end
      end
   endgenerate

   logic [2:0] fix_free;
   logic fix_found;
   logic [1:0] cyc_free;
   logic cyc_found;
   always_comb
   begin
      logic [1:0] p;
      fix_free = 3'h0;
      fix_found = 1'b0;
      cyc_free = 2'h0;
      cyc_found = 1'b0;
      p = 2'h0;
      for (int i = psc_pkg::NUM_PUMPS - 1; i > 0; i--)
      begin
         if (fix_pool[i] && !mains_reg[i])
         begin
            fix_free = 3'(i);
            fix_found = 1'b1;
         end
      end
      for (int k = psc_pkg::CYC_PUMPS - 1; k > 0; k--)
      begin
         p = 2'(drive_reg + 2'(k));
         if (cyc_pool[p] && !mains_reg[p])
         begin
            cyc_free = p;
            cyc_found = 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Threshold timers on a 10 ms tick
   // ----------------------------------------------------------------
   logic [31:0] div_reg;
   logic tick_reg;
   logic [16:0] up_cnt_reg, lo_cnt_reg;
   logic [7:0] sw_cnt_reg;
   wire [10:0] add_th = (upper_limit > {2'h0, cfg_reg.bias}) ?
                        11'(upper_limit - {2'h0, cfg_reg.bias}) : 11'h0; // R20
   wire [10:0] rem_th = 11'(lower_limit) + 11'(cfg_reg.bias); // R20
   wire at_upper = {1'b0, out_freq} >= add_th;
   wire at_lower = {1'b0, out_freq} <= rem_th;
   wire in_run = state_reg == PS_RUN;
   wire [16:0] up_lim = 17'(cfg_reg.up_dur * psc_pkg::TICKS_PER_DUR);
   wire [16:0] lo_lim = 17'(cfg_reg.lo_dur * psc_pkg::TICKS_PER_DUR);
   wire up_done = up_cnt_reg >= up_lim;
   wire lo_done = lo_cnt_reg >= lo_lim;
   wire sw_done = sw_cnt_reg >= cfg_reg.sw_time;
   wire in_xfer = (state_reg == PS_XFER_OFF) || (state_reg == PS_XFER_ON);

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         div_reg <= 32'h0;
         tick_reg <= 1'b0;
      end
      else
      begin
         tick_reg <= div_reg == 32'(TICK_CYCLES - 1);
         div_reg <= (div_reg == 32'(TICK_CYCLES - 1)) ? 32'h0 : div_reg + 32'h1;
      end
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         up_cnt_reg <= 17'h0;
         lo_cnt_reg <= 17'h0;
         sw_cnt_reg <= 8'h0;
      end
      else
      begin
         if (!in_run || !at_upper)
            up_cnt_reg <= 17'h0; // R21
         else if (tick_reg && !up_done)
            up_cnt_reg <= up_cnt_reg + 17'h1; // R16
         if (!in_run || !at_lower || (cnt_next != cnt_reg))
            lo_cnt_reg <= 17'h0; // R17 R21
         else if (tick_reg && !lo_done)
            lo_cnt_reg <= lo_cnt_reg + 17'h1; // R17
         if (!in_xfer || (state_next != state_reg))
            sw_cnt_reg <= 8'h0;
         else if (tick_reg && !sw_done)
            sw_cnt_reg <= sw_cnt_reg + 8'h1; // R18
      end
   end

   // ----------------------------------------------------------------
   // Staging sequencer
   // ----------------------------------------------------------------
   wire [2:0] pop_idx = lifo ? order_reg[3'(cnt_reg - 4'h1)] : order_reg[0];
   always_comb
   begin
      state_next = state_reg;
      mains_next = mains_reg;
      drive_next = drive_reg;
      conn_next = conn_reg;
      cnt_next = cnt_reg;
      ramp_up_next = ramp_up_reg;
      for (int i = 0; i < psc_pkg::NUM_PUMPS; i++)
         order_next[i] = order_reg[i];
      if (!active)
      begin
         state_next = PS_IDLE; // R1
         mains_next = 8'h0;
         conn_next = 1'b0;
         cnt_next = 4'h0;
      end
      else if (state_reg != PS_IDLE && !run_cmd)
      begin
         state_next = PS_IDLE;
         if (!hold_on_stop)
         begin
            mains_next = 8'h0; // R2 R4 R5 R6
            cnt_next = 4'h0;
            conn_next = 1'b0;
         end
      end
      else
      begin
         case (state_reg)
            PS_IDLE:
               if (run_cmd)
               begin
                  conn_next = 1'b1;
                  state_next = PS_RUN;
               end
            PS_RUN:
               if (up_done && !cyc_mode && fix_found)
               begin
                  mains_next[fix_free] = 1'b1; // R12
                  order_next[cnt_reg[2:0]] = fix_free;
                  cnt_next = cnt_reg + 4'h1;
                  ramp_up_next = 1'b0; // R13
                  state_next = PS_RAMP;
               end
               else if (up_done && cyc_mode && cyc_found)
               begin
                  conn_next = 1'b0; // R15
                  state_next = PS_XFER_OFF;
               end
               else if (lo_done && cnt_reg != 4'h0)
               begin
                  mains_next[pop_idx] = 1'b0; // R2 R4 R5
                  cnt_next = cnt_reg - 4'h1;
                  if (!lifo)
                  begin
                     for (int i = 0; i < psc_pkg::NUM_PUMPS - 1; i++)
                        order_next[i] = order_reg[i+1];
                  end
                  if (!cyc_mode)
                  begin
                     ramp_up_next = 1'b1; // R13
                     state_next = PS_RAMP;
                  end
               end
            PS_RAMP:
               if (ramp_up_reg ? (out_freq >= upper_limit) : (out_freq <= lower_limit))
                  state_next = PS_RUN; // R13
            PS_XFER_OFF:
               if (sw_done)
               begin
                  mains_next[{1'b0, drive_reg}] = 1'b1; // R15
                  order_next[cnt_reg[2:0]] = {1'b0, drive_reg};
                  cnt_next = cnt_reg + 4'h1;
                  state_next = PS_XFER_ON;
               end
            PS_XFER_ON:
               if (sw_done)
               begin
                  drive_next = cyc_free; // R5 R15 R18
                  conn_next = 1'b1;
                  state_next = PS_RUN;
               end
            default: state_next = PS_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Relay and drive outputs
   // ----------------------------------------------------------------
   logic [7:0] relay_next;
   always_comb
   begin
      relay_next = 8'h0;
      if (active && !cyc_mode)
         relay_next = mains_next & fix_pool; // R8 R12
      else if (active)
      begin
         for (int p = 0; p < psc_pkg::CYC_PUMPS; p++)
         begin
            relay_next[2*p] = conn_next && (drive_next == 2'(p)); // R14
            relay_next[2*p+1] = mains_next[p];
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         state_reg <= PS_IDLE;
         mains_reg <= 8'h0;
         drive_reg <= 2'h0;
         conn_reg <= 1'b0;
         cnt_reg <= 4'h0;
         ramp_up_reg <= 1'b0;
         staging_relays <= 8'h0;
         drive_run <= 1'b0;
         pid_hold <= 1'b0;
         ramp_to_upper <= 1'b0;
         ramp_to_lower <= 1'b0;
         for (int i = 0; i < psc_pkg::NUM_PUMPS; i++)
            order_reg[i] <= 3'h0;
      end
      else
      begin
         state_reg <= state_next;
         mains_reg <= mains_next;
         drive_reg <= drive_next;
         conn_reg <= conn_next;
         cnt_reg <= cnt_next;
         ramp_up_reg <= ramp_up_next;
         staging_relays <= relay_next;
         drive_run <= (state_next != PS_IDLE) && conn_next; // R3
         pid_hold <= (state_next == PS_RAMP); // R13
         ramp_to_upper <= (state_next == PS_RAMP) && ramp_up_next;
         ramp_to_lower <= (state_next == PS_RAMP) && !ramp_up_next;
         for (int i = 0; i < psc_pkg::NUM_PUMPS; i++)
            order_reg[i] <= order_next[i];
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   property p_off_no_relays;
      @(posedge sys_clk) disable iff (rst) !active |=> staging_relays == 8'h0;
   endproperty
   a_off_no_relays: assert property (p_off_no_relays) else $error("relays on while off"); // R1
   property p_no_card;
      @(posedge sys_clk) disable iff (rst) !card_present |=> state_reg == PS_IDLE;
   endproperty
   a_no_card: assert property (p_no_card) else $error("active without card"); // R7
   property p_hold_keeps;
      @(posedge sys_clk) disable iff (rst)
         (hold_on_stop && !run_cmd && state_reg == PS_RUN) |=> mains_reg == $past(mains_reg);
   endproperty
   a_hold_keeps: assert property (p_hold_keeps) else $error("relays dropped on stop"); // R3
   property p_stop_all;
      @(posedge sys_clk) disable iff (rst)
         (active && !hold_on_stop && !run_cmd && state_reg != PS_IDLE) |=>
         (staging_relays == 8'h0 && !drive_run);
   endproperty
   a_stop_all: assert property (p_stop_all) else $error("pumps left on at stop"); // R2
   property p_fix_pool;
      @(posedge sys_clk) disable iff (rst)
         (active && !cyc_mode) |=> (staging_relays & ~$past(fix_pool)) == 8'h0;
   endproperty
   a_fix_pool: assert property (p_fix_pool) else $error("disabled relay staged"); // R10
   property p_cnt_max;
      @(posedge sys_clk) disable iff (rst) cyc_mode |-> cnt_reg < 4'(psc_pkg::CYC_PUMPS);
   endproperty
   a_cnt_max: assert property (p_cnt_max) else $error("too many cycle pumps"); // R9
   property p_add_wait;
      @(posedge sys_clk) disable iff (rst)
         (state_reg == PS_RUN && state_next == PS_RAMP && !ramp_up_next) |-> up_done;
   endproperty
   a_add_wait: assert property (p_add_wait) else $error("added before duration"); // R16
   property p_rem_wait;
      @(posedge sys_clk) disable iff (rst)
         (in_run && active && run_cmd && cnt_next < cnt_reg) |-> lo_done;
   endproperty
   a_rem_wait: assert property (p_rem_wait) else $error("removed before duration"); // R17
   property p_restart;
      @(posedge sys_clk) disable iff (rst) !at_upper |=> up_cnt_reg == 17'h0;
   endproperty
   a_restart: assert property (p_restart) else $error("timer kept value"); // R21
   property p_xfer_wait;
      @(posedge sys_clk) disable iff (rst)
         (state_reg == PS_XFER_OFF && state_next == PS_XFER_ON) |-> sw_done && !conn_reg;
   endproperty
   a_xfer_wait: assert property (p_xfer_wait) else $error("transfer too early"); // R15
   property p_ramp_hold;
      @(posedge sys_clk) disable iff (rst) (state_reg == PS_RAMP) |-> pid_hold;
   endproperty
   a_ramp_hold: assert property (p_ramp_hold) else $error("PID not held"); // R13
   property p_ack_pulse;
      @(posedge sys_clk) disable iff (rst) wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   c_fix_add: cover property (@(posedge sys_clk) disable iff (rst)
      state_reg == PS_RUN ##1 state_reg == PS_RAMP);
   c_cyc_xfer: cover property (@(posedge sys_clk) disable iff (rst)
      state_reg == PS_XFER_ON ##1 state_reg == PS_RUN);
   c_hold_stop: cover property (@(posedge sys_clk) disable iff (rst)
      hold_on_stop && state_reg == PS_IDLE && mains_reg != 8'h0);
endmodule : psc_top
`default_nettype wire

/* File: tb/psc_contactor_model.sv */
/*
 Contactor model: each contact follows its relay after a close or open delay.
 Assumes cycle-mode pairing: bit 2p drives pump p, bit 2p+1 puts it on mains.
*/
`timescale 1ns/1ns
`default_nettype none
module psc_contactor_model #(
   parameter int CLOSE_CYC = 60,
   parameter int OPEN_CYC = 30
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [7:0] staging_relays,
   output logic short_seen
);
   logic [7:0] closed;
   int cnt [8];
   // Both delays stay below the shortest switch time
   always @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         closed <= 8'h00;
         short_seen <= 1'b0;
         cnt <= '{default: 0};
      end
      else
      begin
         for (int i = 0; i < 8; i++)
         begin
            if (staging_relays[i] == closed[i])
               cnt[i] <= 0;
            else if (cnt[i] >= (closed[i] ? OPEN_CYC : CLOSE_CYC))
               closed[i] <= staging_relays[i];
            else
               cnt[i] <= cnt[i] + 1;
         end
         for (int p = 0; p < 4; p++)
            if (closed[2*p] && closed[2*p+1])
               short_seen <= 1'b1;
      end
   end
endmodule : psc_contactor_model
`default_nettype wire

/* File: tb/tb_psc_top.sv */
/*
 Bench for the pump staging controller.
 Assumes psc_pkg, psc_top and the contactor model; limits 80 and 20 percent.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_psc_top;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic ack, drv, hold, to_up, to_lo, short_seen;
   logic card = 1'b1;
   logic run = 1'b0;
   logic [9:0] freq = 10'h1f4;
   logic [7:0] relays;
   int n_fail = 0;
   int compares = 0;
   always #50 sys_clk = ~sys_clk;
   psc_top #(.TICK_CYCLES(10)) psc_top_inst (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .card_present(card), .run_cmd(run), .out_freq(freq),
      .upper_limit(10'h320), .lower_limit(10'h0c8), .staging_relays(relays), .drive_run(drv),
      .pid_hold(hold), .ramp_to_upper(to_up), .ramp_to_lower(to_lo));
   psc_contactor_model psc_contactor_model_inst (.sys_clk(sys_clk), .rst(rst),
      .staging_relays(relays), .short_seen(short_seen));
   task tally_and_finish;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : tally_and_finish
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : tick
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp);
      int k;
      @(posedge sys_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      k = 0;
      do
      begin
         @(posedge sys_clk);
         k++;
      end while (ack !== 1'b1 && k < 20);
      chk("ack", 32'h1, {31'h0, ack});
      if (ack !== 1'b1)
         tally_and_finish;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (!w)
         chk("read", exp, rdat);
   endtask : wb
   task wait_rel(input logic [7:0] exp, input int max);
      int k;
      k = 0;
      while (relays !== exp && k < max)
      begin
         @(posedge sys_clk);
         k++;
      end
      chk("relays", {24'h0, exp}, {24'h0, relays});
      if (relays !== exp)
         tally_and_finish;
   endtask : wait_rel
   task setup(input logic [2:0] m, input logic [7:0] en);
      rst <= 1'b1;
      run <= 1'b0;
      tick(2);
      rst <= 1'b0;
      wb(1'b1, psc_pkg::ADR_MODE, {29'h0, m}, 32'h0);
      wb(1'b1, psc_pkg::ADR_RELAY_EN, {24'h0, en}, 32'h0);
      wb(1'b1, psc_pkg::ADR_BIAS, 32'h32, 32'h0);
      freq <= 10'h2ee;
      run <= 1'b1;
   endtask : setup
   task stop_chk(input logic [7:0] stop);
      freq <= 10'h1f4;
      run <= 1'b0;
      tick(4);
      chk("stop", {24'h0, stop}, {24'h0, relays});
      chk("drive", 32'h0, {31'h0, drv});
   endtask : stop_chk
   task run_fixed(input logic [2:0] m, input logic [7:0] rm, input logic [7:0] stop);
      setup(m, 8'hfe);
      tick(700);
      freq <= 10'h1f4;
      tick(20);
      freq <= 10'h2ee;
      tick(900);
      chk("early", 32'h0, {24'h0, relays});
      wait_rel(8'h02, 300);
      chk("hold", 32'h1, {31'h0, hold});
      chk("ramp_lo", 32'h1, {31'h0, to_lo});
      freq <= 10'h0c8;
      tick(4);
      chk("resume", 32'h0, {31'h0, hold});
      freq <= 10'h2ee;
      wait_rel(8'h06, 1300);
      freq <= 10'h0c8;
      tick(4);
      if (rm !== 8'h00)
      begin
         wait_rel(rm, 1300);
         chk("ramp_up", 32'h1, {31'h0, to_up});
      end
      stop_chk(stop);
   endtask : run_fixed
   task run_cycle(input logic [2:0] m, input logic [7:0] en, input logic [7:0] fin,
      input logic [7:0] stop);
      setup(m, en);
      wait_rel(8'h01, 50);
      wait_rel(8'h00, 1300);
      tick(85);
      chk("gap_off", 32'h0, {24'h0, relays});
      wait_rel(8'h02, 40);
      tick(85);
      chk("gap_on", 32'h2, {24'h0, relays});
      wait_rel(fin, 40);
      stop_chk(stop);
      chk("short", 32'h0, {31'h0, short_seen});
   endtask : run_cycle
   initial
   begin
      tick(2);
      rst <= 1'b0;
      wb(1'b0, psc_pkg::ADR_UP_DUR, 32'h0, {16'h0, psc_pkg::UP_DUR_RST});
      wb(1'b0, psc_pkg::ADR_SW_TIME, 32'h0, {24'h0, psc_pkg::SW_TIME_RST});
      wb(1'b0, 8'h1c, 32'h0, 32'h0);
      wb(1'b1, psc_pkg::ADR_MODE, 32'h7, 32'h0);
      wb(1'b0, psc_pkg::ADR_MODE, 32'h0, 32'h0);
      wb(1'b1, psc_pkg::ADR_RELAY_EN, 32'hff, 32'h0);
      wb(1'b0, psc_pkg::ADR_RELAY_EN, 32'h0, 32'hfe);
      card <= 1'b0;
      wb(1'b1, psc_pkg::ADR_MODE, 32'h1, 32'h0);
      run <= 1'b1;
      freq <= 10'h2ee;
      tick(1300);
      chk("no_card", 32'h0, {24'h0, relays});
      card <= 1'b1;
      run_fixed(psc_pkg::MODE_LIFO, 8'h02, 8'h00);
      run_fixed(psc_pkg::MODE_FIX_HOLD, 8'h00, 8'h06);
      run_fixed(psc_pkg::MODE_FIX_FIFO, 8'h04, 8'h00);
      run_cycle(psc_pkg::MODE_CYC_FIFO, 8'hfe, 8'h06, 8'h00);
      run_cycle(psc_pkg::MODE_CYC_HOLD, 8'hfe, 8'h06, 8'h06);
      run_cycle(psc_pkg::MODE_CYC3, 8'hf2, 8'h12, 8'h00);
      tally_and_finish;
   end
endmodule : tb_psc_top
`default_nettype wire
